// file: design/mmu_tlb_pkg.sv
// shared constants and carrier types for the translation buffer block
package mmu_tlb_pkg;
    localparam int VA_W = 48;
    localparam int PA_W = 41;
    localparam int CTX_W = 13;
    localparam int PPN_LSB = 13;
    localparam int PPN_W = PA_W - PPN_LSB;
    localparam int FLAG_W = 4;

    typedef logic [1:0] psize_t;
    localparam psize_t PS_8K = 2'h0;
    localparam psize_t PS_64K = 2'h1;
    localparam psize_t PS_512K = 2'h2;
    localparam psize_t PS_4M = 2'h3;
    localparam int SHIFT_8K = 13;
    localparam int SHIFT_64K = 16;
    localparam int SHIFT_512K = 19;
    localparam int SHIFT_4M = 22;
    // default page size of the first and second set-indexed bank
    localparam psize_t BANK0_SIZE = PS_8K;
    localparam psize_t BANK1_SIZE = PS_4M;

    localparam logic [1:0] CTX_PRIMARY = 2'h0;
    localparam logic [1:0] CTX_SECONDARY = 2'h1;
    localparam logic [1:0] CTX_NUCLEUS = 2'h2;
    localparam logic [1:0] CTX_SHARED = 2'h3;

    localparam logic [7:0] ASI_INSTR_REGS = 8'h50;
    localparam logic [7:0] ASI_DATA_REGS = 8'h58;
    localparam logic [63:0] VA_FAULT_PHYS = 64'h78;
    localparam logic [7:0] ASI_PHYS_CACHED = 8'h14;
    localparam logic [7:0] ASI_PHYS_CACHED_LE = 8'h1c;
    localparam logic [7:0] ASI_PHYS_SIDE_EFFECT = 8'h15;
    localparam logic [7:0] ASI_PHYS_SIDE_EFFECT_LE = 8'h1d;
    localparam logic [7:0] ASI_ATOMIC_QUAD_PHYS = 8'h34;
    localparam logic [7:0] ASI_ATOMIC_QUAD_PHYS_LE = 8'h3c;

    // fault physical address keeps bits 40:3 only
    localparam logic [63:0] FPA_MASK = 64'h0000_01ff_ffff_fff8;
    localparam logic [63:0] FAULT_RESET = 64'h0;
    localparam logic [63:0] SIMD_SP_OFFSET = 64'h4;
    localparam logic [63:0] SIMD_DP_OFFSET = 64'h8;

    typedef enum logic [1:0] {DM_PAGE, DM_CONTEXT, DM_ALL} demap_e;

    typedef struct packed {
        logic valid;
        logic [VA_W-1:0] va;
        logic [CTX_W-1:0] ctx;
        psize_t psize;
        logic lock;
        logic global;
        logic [PPN_W-1:0] ppn;
    } entry_s;

    typedef struct packed {
        logic multi_page_size_select;
        logic force_full_search_write;
    } cfg_s;

    typedef struct packed {
        logic [CTX_W-1:0] ctx;
        psize_t [1:0] psize;
    } ctx_reg_s;

    typedef struct packed {
        logic valid;
        logic [VA_W-1:0] va;
        logic [CTX_W-1:0] ctx;
        logic [1:0] sel;
    } lookup_s;

    typedef struct packed {
        logic valid;
        demap_e kind;
        logic [1:0] sel;
        logic [VA_W-1:0] va;
    } demap_s;

    typedef struct packed {
        logic valid;
        logic [63:0] va;
        logic ext_only;
        logic dbl;
    } watch_s;

    typedef struct packed {
        logic valid;
        logic [FLAG_W-1:0] flags;
        logic [PA_W-1:0] pa;
    } err_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] asi;
        logic [63:0] va;
        logic [63:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic phys_cacheable_attr;
        logic invert_endian_attr;
        logic virt_cacheable_attr;
        logic side_effect;
        logic privileged;
        logic writable;
        logic nonfault_only_attr;
        psize_t size;
    } attr_s;
endpackage

// file: design/mmu_tlb_replace_demap_fault_addr.sv
// translation buffer replacement, invalidation, fault address and bypass
// Summary of operation
// RL1 - watchpoint fault keeps instruction's address
// RL2 - extended-only watchpoint adds four or eight
// RL3 - invalidate index size: 8KB/4MB by default
// RL4 - multi-page select uses chosen context sizes
// RL5 - only matching page size set-indexed entries removed
// RL6 - invalidate-all clears every set-indexed entry
// RL7 - shared context never an invalidation target
// RL8 - software gives valid context for invalidation
// RL9 - physical fault registers keep bits 40:3
// RL10 - update only on flagged access error
// RL11 - atomic quad bypass spaces 34 and 3c
// RL12 - bypass spaces use fixed 8KB attributes
// RL13 - set-indexed target needs unlocked qualifying entry
// RL14 - set index from page number, LRU victim
// RL15 - fully searched write takes first empty
// RL16 - else lowest unlocked unused, clearing used
// RL17 - all locked: write dropped silently
// RL18 - duplicate match suppresses fully searched write
// RL19 - direct writes skip page size check
// RL20 - hit sets hidden used flag
`timescale 1ns/1ps
module mmu_tlb_replace_demap_fault_addr #(
    parameter int SETS = 64,
    parameter int FS_N = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // control and context register settings
    input wire mmu_tlb_pkg::cfg_s i_cfg,
    input wire mmu_tlb_pkg::ctx_reg_s [2:0] i_ctx_regs,
    input wire mmu_tlb_pkg::psize_t [1:0] i_ext_ctx_psize,
    // translation lookup
    input wire mmu_tlb_pkg::lookup_s i_lookup,
    output logic o_lookup_hit,
    output logic [mmu_tlb_pkg::PPN_W-1:0] o_lookup_ppn,
    output logic o_lookup_multi_hit,
    // automatic write and invalidation
    input wire mmu_tlb_pkg::entry_s i_write_entry,
    input wire logic i_write_valid,
    output logic o_write_dropped,
    input wire mmu_tlb_pkg::demap_s i_demap,
    // direct write into the set-indexed buffer
    input wire logic i_direct_valid,
    input wire logic i_direct_bank,
    input wire logic [$clog2(SETS)-1:0] i_direct_set,
    input wire logic i_direct_way,
    input wire mmu_tlb_pkg::entry_s i_direct_entry,
    // fault events
    input wire mmu_tlb_pkg::watch_s i_watch,
    input wire mmu_tlb_pkg::err_s i_instr_err,
    input wire mmu_tlb_pkg::err_s i_data_err,
    output logic [63:0] o_data_fault_virt_address,
    // alternate-space register access
    input wire mmu_tlb_pkg::reg_req_s i_reg,
    output logic o_reg_ack,
    output logic [63:0] o_reg_rdata,
    // bypass attribute lookup
    input wire logic i_bypass_valid,
    input wire logic [7:0] i_bypass_asi,
    output logic o_bypass_hit,
    output mmu_tlb_pkg::attr_s o_bypass_attr
);
    localparam int SIDX_W = $clog2(SETS);
    localparam int FS_W = $clog2(FS_N);

    initial begin
        if (SETS < 2 || (SETS & (SETS - 1)) != 0 || FS_N < 2) begin
            $error("unsupported buffer geometry");
        end
    end

    function automatic int page_shift(input mmu_tlb_pkg::psize_t p);
        unique case (p)
            mmu_tlb_pkg::PS_8K: return mmu_tlb_pkg::SHIFT_8K;
            mmu_tlb_pkg::PS_64K: return mmu_tlb_pkg::SHIFT_64K;
            mmu_tlb_pkg::PS_512K: return mmu_tlb_pkg::SHIFT_512K;
            mmu_tlb_pkg::PS_4M: return mmu_tlb_pkg::SHIFT_4M;
        endcase
    endfunction

    function automatic logic [SIDX_W-1:0] page_index(
        input logic [mmu_tlb_pkg::VA_W-1:0] va,
        input mmu_tlb_pkg::psize_t p);
        logic [mmu_tlb_pkg::VA_W-1:0] s;
        s = va >> page_shift(p);
        return s[SIDX_W-1:0];
    endfunction

    function automatic logic hits(input mmu_tlb_pkg::entry_s e,
        input logic [mmu_tlb_pkg::VA_W-1:0] va,
        input logic [mmu_tlb_pkg::CTX_W-1:0] ctx);
        logic [mmu_tlb_pkg::VA_W-1:0] m;
        m = {mmu_tlb_pkg::VA_W{1'b1}} << page_shift(e.psize);
        return e.valid && ((e.va ^ va) & m) == '0 &&
            (e.global || e.ctx == ctx);
    endfunction

    function automatic mmu_tlb_pkg::psize_t op_size(input logic b,
        input logic [1:0] sel);
        logic [1:0] k;
        k = (sel == mmu_tlb_pkg::CTX_SHARED) ? mmu_tlb_pkg::CTX_PRIMARY : sel;
        if (i_cfg.multi_page_size_select) begin
            return i_ctx_regs[k].psize[b]; // RL4
        end
        return b ? mmu_tlb_pkg::BANK1_SIZE : mmu_tlb_pkg::BANK0_SIZE; // RL3
    endfunction

    // lowest set bit, found flag in the top bit
    function automatic logic [FS_W:0] first_set(input logic [FS_N-1:0] v);
        logic [FS_W:0] r;
        r = '0;
        for (int k = FS_N - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = {1'b1, FS_W'(k)};
            end
        end
        return r;
    endfunction

    function automatic logic [63:0] fpa_of(input logic [63:0] x);
        return x & mmu_tlb_pkg::FPA_MASK; // RL9
    endfunction

    mmu_tlb_pkg::entry_s si [2][SETS][2], next_si [2][SETS][2];
    logic [SETS-1:0] lru [2], next_lru [2];
    mmu_tlb_pkg::entry_s fs [FS_N], next_fs [FS_N];
    logic [FS_N-1:0] used, next_used;
    logic next_lookup_hit, next_lookup_multi_hit, next_write_dropped;
    logic [mmu_tlb_pkg::PPN_W-1:0] next_lookup_ppn;

    always_comb begin
        int cnt;
        logic to_si, bank, dup, way;
        logic [SIDX_W-1:0] idx;
        logic [FS_W:0] pick;
        logic [FS_N-1:0] empty, free, unlocked, hitv;
        logic [mmu_tlb_pkg::CTX_W-1:0] dctx;
        mmu_tlb_pkg::psize_t psz;
        mmu_tlb_pkg::entry_s e;
        cnt = 0;
        to_si = 1'b0;
        bank = 1'b0;
        dup = 1'b0;
        way = 1'b0;
        idx = '0;
        pick = '0;
        empty = '0;
        free = '0;
        unlocked = '0;
        hitv = '0;
        dctx = '0;
        psz = mmu_tlb_pkg::PS_8K;
        e = i_write_entry;
        next_si = si;
        next_lru = lru;
        next_fs = fs;
        next_used = used;
        next_lookup_hit = 1'b0;
        next_lookup_ppn = o_lookup_ppn;
        next_lookup_multi_hit = 1'b0;
        next_write_dropped = 1'b0;
        if (i_lookup.valid) begin
            for (int b = 0; b < 2; b++) begin
                psz = op_size(b[0], i_lookup.sel);
                idx = page_index(i_lookup.va, psz);
                for (int w = 0; w < 2; w++) begin
                    if (hits(si[b][idx][w], i_lookup.va, i_lookup.ctx)) begin
                        cnt = cnt + 1;
                        next_lookup_ppn = si[b][idx][w].ppn;
                        next_lru[b][idx] = ~w[0]; // RL14
                    end
                end
            end
            for (int k = 0; k < FS_N; k++) begin
                if (hits(fs[k], i_lookup.va, i_lookup.ctx)) begin
                    cnt = cnt + 1;
                    next_lookup_ppn = fs[k].ppn;
                    next_used[k] = 1'b1; // RL20
                    hitv[k] = 1'b1;
                end
            end
            next_lookup_hit = cnt != 0;
            next_lookup_multi_hit = cnt > 1;
        end
        if (i_demap.valid && i_demap.sel != mmu_tlb_pkg::CTX_SHARED) begin // RL7
            dctx = i_ctx_regs[i_demap.sel].ctx;
            for (int b = 0; b < 2; b++) begin
                psz = op_size(b[0], i_demap.sel); // RL3
                idx = page_index(i_demap.va, psz);
                for (int s = 0; s < SETS; s++) begin
                    for (int w = 0; w < 2; w++) begin
                        e = si[b][s][w];
                        unique case (i_demap.kind)
                            mmu_tlb_pkg::DM_ALL: begin
                                next_si[b][s][w].valid = 1'b0; // RL6
                            end
                            mmu_tlb_pkg::DM_PAGE: begin
                                if (SIDX_W'(s) == idx && e.psize == psz &&
                                    hits(e, i_demap.va, dctx)) begin // RL5
                                    next_si[b][s][w].valid = 1'b0;
                                end
                            end
                            mmu_tlb_pkg::DM_CONTEXT: begin
                                if (e.psize == psz && !e.global &&
                                    e.ctx == dctx) begin // RL5
                                    next_si[b][s][w].valid = 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            for (int k = 0; k < FS_N; k++) begin
                e = fs[k];
                if ((i_demap.kind == mmu_tlb_pkg::DM_ALL && !e.lock) ||
                    (i_demap.kind == mmu_tlb_pkg::DM_PAGE &&
                     hits(e, i_demap.va, dctx)) ||
                    (i_demap.kind == mmu_tlb_pkg::DM_CONTEXT &&
                     !e.global && e.ctx == dctx)) begin
                    next_fs[k].valid = 1'b0;
                    next_used[k] = 1'b0;
                end
            end
        end else if (i_write_valid) begin
            e.valid = 1'b1;
            if (i_cfg.multi_page_size_select) begin
                to_si = e.psize == i_ext_ctx_psize[0] ||
                    e.psize == i_ext_ctx_psize[1];
                bank = e.psize != i_ext_ctx_psize[0];
            end else begin
                to_si = e.psize == mmu_tlb_pkg::BANK0_SIZE ||
                    e.psize == mmu_tlb_pkg::BANK1_SIZE;
                bank = e.psize != mmu_tlb_pkg::BANK0_SIZE;
            end
            to_si = to_si && !e.lock && !e.global &&
                !i_cfg.force_full_search_write; // RL13
            if (to_si) begin
                idx = page_index(e.va, e.psize); // RL14
                if (!si[bank][idx][0].valid) begin
                    way = 1'b0;
                end else if (!si[bank][idx][1].valid) begin
                    way = 1'b1;
                end else begin
                    way = lru[bank][idx]; // RL14
                end
                next_si[bank][idx][way] = e;
                next_lru[bank][idx] = ~way;
            end else begin
                for (int k = 0; k < FS_N; k++) begin
                    empty[k] = !fs[k].valid;
                    unlocked[k] = !fs[k].valid || !fs[k].lock;
                    free[k] = fs[k].valid && !fs[k].lock && !used[k];
                    if (hits(fs[k], e.va, e.ctx)) begin
                        dup = 1'b1;
                    end
                end
                if (dup) begin
                    next_write_dropped = 1'b1; // RL18
                end else if (unlocked == '0) begin
                    next_write_dropped = 1'b1; // RL17
                end else begin
                    pick = first_set(empty); // RL15
                    if (!pick[FS_W]) begin
                        pick = first_set(free); // RL16
                    end
                    if (!pick[FS_W]) begin
                        // all used: clear them, a hit in this cycle wins
                        next_used = hitv; // RL16
                        pick = first_set(unlocked);
                    end
                    next_fs[pick[FS_W-1:0]] = e;
                end
            end
        end else if (i_direct_valid) begin
            next_si[i_direct_bank][i_direct_set][i_direct_way] =
                i_direct_entry; // RL19
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            si <= '{default: '0};
            lru <= '{default: '0};
            fs <= '{default: '0};
            used <= '0;
            o_lookup_hit <= 1'b0;
            o_lookup_ppn <= '0;
            o_lookup_multi_hit <= 1'b0;
            o_write_dropped <= 1'b0;
        end else begin
            si <= next_si;
            lru <= next_lru;
            fs <= next_fs;
            used <= next_used;
            o_lookup_hit <= next_lookup_hit;
            o_lookup_ppn <= next_lookup_ppn;
            o_lookup_multi_hit <= next_lookup_multi_hit;
            o_write_dropped <= next_write_dropped;
        end
    end

    logic [63:0] instr_fault_phys_address, data_fault_phys_address;
    logic [63:0] next_instr_fpa, next_data_fpa, next_dfva, next_reg_rdata;
    logic next_reg_ack, next_bypass_hit;
    mmu_tlb_pkg::attr_s next_bypass_attr;

    always_comb begin
        logic sel_i, sel_d;
        sel_i = i_reg.valid && i_reg.va == mmu_tlb_pkg::VA_FAULT_PHYS &&
            i_reg.asi == mmu_tlb_pkg::ASI_INSTR_REGS;
        sel_d = i_reg.valid && i_reg.va == mmu_tlb_pkg::VA_FAULT_PHYS &&
            i_reg.asi == mmu_tlb_pkg::ASI_DATA_REGS;
        next_instr_fpa = instr_fault_phys_address;
        next_data_fpa = data_fault_phys_address;
        next_dfva = o_data_fault_virt_address;
        next_reg_ack = sel_i || sel_d;
        next_reg_rdata = '0;
        if (sel_i && !i_reg.write) begin
            next_reg_rdata = instr_fault_phys_address;
        end
        if (sel_d && !i_reg.write) begin
            next_reg_rdata = data_fault_phys_address;
        end
        if (sel_i && i_reg.write) begin
            next_instr_fpa = fpa_of(i_reg.wdata); // RL9
        end
        if (sel_d && i_reg.write) begin
            next_data_fpa = fpa_of(i_reg.wdata); // RL9
        end
        // hardware capture wins over a software write
        if (i_instr_err.valid && i_instr_err.flags != '0) begin // RL10
            next_instr_fpa = fpa_of(64'(i_instr_err.pa));
        end
        if (i_data_err.valid && i_data_err.flags != '0) begin // RL10
            next_data_fpa = fpa_of(64'(i_data_err.pa));
        end
        if (i_watch.valid) begin
            next_dfva = i_watch.va; // RL1
            if (i_watch.ext_only) begin
                next_dfva = i_watch.va + (i_watch.dbl ?
                    mmu_tlb_pkg::SIMD_DP_OFFSET :
                    mmu_tlb_pkg::SIMD_SP_OFFSET); // RL2
            end
        end
        next_bypass_attr = '0;
        next_bypass_attr.size = mmu_tlb_pkg::PS_8K; // RL12
        next_bypass_hit = 1'b0;
        if (i_bypass_valid) begin
            unique case (i_bypass_asi)
                mmu_tlb_pkg::ASI_PHYS_CACHED,
                mmu_tlb_pkg::ASI_PHYS_CACHED_LE: begin
                    next_bypass_hit = 1'b1;
                    next_bypass_attr.phys_cacheable_attr = 1'b1; // RL12
                    next_bypass_attr.writable = 1'b1;
                end
                mmu_tlb_pkg::ASI_PHYS_SIDE_EFFECT,
                mmu_tlb_pkg::ASI_PHYS_SIDE_EFFECT_LE: begin
                    next_bypass_hit = 1'b1;
                    next_bypass_attr.side_effect = 1'b1; // RL12
                    next_bypass_attr.writable = 1'b1;
                end
                mmu_tlb_pkg::ASI_ATOMIC_QUAD_PHYS,
                mmu_tlb_pkg::ASI_ATOMIC_QUAD_PHYS_LE: begin // RL11
                    next_bypass_hit = 1'b1;
                    next_bypass_attr.phys_cacheable_attr = 1'b1; // RL12
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            instr_fault_phys_address <= mmu_tlb_pkg::FAULT_RESET;
            data_fault_phys_address <= mmu_tlb_pkg::FAULT_RESET;
            o_data_fault_virt_address <= mmu_tlb_pkg::FAULT_RESET;
            o_reg_ack <= 1'b0;
            o_reg_rdata <= '0;
            o_bypass_hit <= 1'b0;
            o_bypass_attr <= '0;
        end else begin
            instr_fault_phys_address <= next_instr_fpa;
            data_fault_phys_address <= next_data_fpa;
            o_data_fault_virt_address <= next_dfva;
            o_reg_ack <= next_reg_ack;
            o_reg_rdata <= next_reg_rdata;
            o_bypass_hit <= next_bypass_hit;
            o_bypass_attr <= next_bypass_attr;
        end
    end
endmodule

// file: verification/mmu_tlb_sva.sv
// port-level checks for the translation buffer block
`timescale 1ns/1ps
module mmu_tlb_sva (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // watched ports
    input wire mmu_tlb_pkg::watch_s i_watch,
    input wire logic [63:0] o_data_fault_virt_address,
    input wire mmu_tlb_pkg::reg_req_s i_reg,
    input wire logic o_reg_ack,
    input wire logic [63:0] o_reg_rdata,
    input wire logic i_bypass_valid,
    input wire logic [7:0] i_bypass_asi,
    input wire logic o_bypass_hit,
    input wire mmu_tlb_pkg::attr_s o_bypass_attr
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    sequence s_fpa;
        i_reg.valid && i_reg.va == mmu_tlb_pkg::VA_FAULT_PHYS
        && (i_reg.asi | 8'h08) == 8'h58;
    endsequence
    // little-endian forms set bit 3
    sequence s_byp(logic [7:0] a);
        i_bypass_valid && (i_bypass_asi | 8'h08) == (a | 8'h08);
    endsequence
    AST_ACK: assert property (s_fpa |=> o_reg_ack)
        else $error("fault access not acked");
    AST_NOACK: assert property (i_reg.valid
        && (i_reg.asi | 8'h08) != 8'h58 |=> !o_reg_ack)
        else $error("unmapped access acked");
    AST_RD_MASK: assert property (o_reg_ack |->
        (o_reg_rdata & ~mmu_tlb_pkg::FPA_MASK) == 64'h0)
        else $error("bits outside 40:3 read nonzero");
    AST_WATCH: assert property (i_watch.valid && !i_watch.ext_only
        |=> o_data_fault_virt_address == $past(i_watch.va))
        else $error("watch address lost");
    AST_WATCH_EXT: assert property (i_watch.valid && i_watch.ext_only
        |=> o_data_fault_virt_address == $past(i_watch.va)
        + ($past(i_watch.dbl) ? 64'h8 : 64'h4))
        else $error("watch offset wrong");
    AST_QUAD: assert property (s_byp(8'h34)
        |=> o_bypass_hit && o_bypass_attr == 9'h100)
        else $error("quad attr wrong");
    AST_CACHED: assert property (s_byp(8'h14)
        |=> o_bypass_hit && o_bypass_attr == 9'h108)
        else $error("cached attr wrong");
    AST_SIDE: assert property (s_byp(8'h15)
        |=> o_bypass_hit && o_bypass_attr == 9'h028)
        else $error("side attr wrong");
endmodule

// file: verification/core_reg_model.sv
// core-side model issuing fault register accesses
`timescale 1ns/1ps
module core_reg_model (
    // clock
    input wire logic i_clock,
    // register port
    output mmu_tlb_pkg::reg_req_s o_reg,
    input wire logic i_ack,
    input wire logic [63:0] i_rdata
);
    initial o_reg = '0;
    task automatic access(input logic w, input logic [7:0] asi,
        input logic [63:0] wd, output logic ack, output logic [63:0] rd);
        @(posedge i_clock);
        o_reg <= '{1'b1, w, asi, 64'h78, wd};
        @(posedge i_clock);
        // released: fields inverted
        o_reg <= '{1'b0, ~w, ~asi, ~64'h78, ~wd};
        #1 ack = i_ack;
        rd = i_rdata;
    endtask
endmodule

// file: verification/test_mmu_tlb_replace_demap_fault_addr.sv
// self-checking bench for the translation buffer block
`timescale 1ns/1ps
module test_mmu_tlb_replace_demap_fault_addr;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    mmu_tlb_pkg::lookup_s lk = '0;
    mmu_tlb_pkg::entry_s we = '0, dent = '0, e1, f;
    mmu_tlb_pkg::demap_s dm = '0;
    mmu_tlb_pkg::watch_s wt = '0;
    mmu_tlb_pkg::err_s ie = '0, de = '0;
    mmu_tlb_pkg::cfg_s cfg = '0;
    mmu_tlb_pkg::reg_req_s rq;
    mmu_tlb_pkg::attr_s battr;
    logic wv = 1'b0, dv = 1'b0, bv = 1'b0;
    logic [5:0] dset = '0;
    logic [7:0] ba = '0;
    logic hit, mhit, drop, ack, bhit, a;
    logic [27:0] ppn;
    logic [63:0] dfva, rdata, rd, x;
    int bad_count = 0, num_checks = 0, cycles = 0;
    logic [7:0] b_asi [7] = '{8'h14, 8'h1c, 8'h15, 8'h1d, 8'h34, 8'h3c,
        8'h40};
    logic [9:0] b_exp [7] = '{10'h308, 10'h308, 10'h228, 10'h228,
        10'h300, 10'h300, 10'h000};
    mmu_tlb_replace_demap_fault_addr u_dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cfg(cfg),
        .i_ctx_regs({3{13'h5, 4'h0}}), .i_ext_ctx_psize('0),
        .i_lookup(lk), .o_lookup_hit(hit), .o_lookup_ppn(ppn),
        .o_lookup_multi_hit(mhit), .i_write_entry(we), .i_write_valid(wv),
        .o_write_dropped(drop), .i_demap(dm), .i_direct_valid(dv),
        .i_direct_bank(1'b0), .i_direct_set(dset), .i_direct_way(1'b0),
        .i_direct_entry(dent), .i_watch(wt), .i_instr_err(ie),
        .i_data_err(de), .o_data_fault_virt_address(dfva), .i_reg(rq),
        .o_reg_ack(ack), .o_reg_rdata(rdata), .i_bypass_valid(bv),
        .i_bypass_asi(ba), .o_bypass_hit(bhit), .o_bypass_attr(battr));
    core_reg_model u_core (.i_clock(i_clock), .o_reg(rq), .i_ack(ack),
        .i_rdata(rdata));
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    task automatic check(input logic [64:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input mmu_tlb_pkg::entry_s e, input logic exp);
        @(posedge i_clock);
        we <= e;
        wv <= 1'b1;
        @(posedge i_clock);
        wv <= 1'b0;
        #1 check(drop, exp);
    endtask
    task automatic lkup(input logic [47:0] va, input logic exp);
        @(posedge i_clock);
        lk <= '{1'b1, va, 13'h5, 2'h0};
        @(posedge i_clock);
        lk.valid <= 1'b0;
        #1 check(hit, exp);
    endtask
    task automatic dmap(input mmu_tlb_pkg::demap_e k, input logic [1:0] s);
        @(posedge i_clock);
        dm <= '{1'b1, k, s, e1.va};
        @(posedge i_clock);
        dm.valid <= 1'b0;
    endtask
    task automatic err(input logic instr, input logic [3:0] fl);
        @(posedge i_clock);
        ie <= '{instr, fl, x[40:0]};
        de <= '{!instr, fl, x[40:0]};
        @(posedge i_clock);
        ie.valid <= 1'b0;
        de.valid <= 1'b0;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles >= 2000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        e1 = '{1'b1, 48'h1234_6000, 13'h5, 2'h0, 1'b0, 1'b0, 28'habcde};
        repeat (10) @(posedge i_clock);
        i_rst_b <= 1'b1;
        u_core.access(1'b0, 8'h58, '0, a, rd);
        check({a, rd}, {1'b1, mmu_tlb_pkg::FAULT_RESET});
        for (int k = 0; k < 7; k++) begin
            @(posedge i_clock);
            bv <= 1'b1;
            ba <= b_asi[k];
            @(posedge i_clock);
            bv <= 1'b0;
            #1 check({bhit, battr}, b_exp[k]);
        end
        $display("test bypass done");
        for (int m = 0; m < 4; m++) begin
            x = 64'h40_1000 + 64'(m * 16);
            @(posedge i_clock);
            wt <= '{1'b1, x, m[1], m[0]};
            @(posedge i_clock);
            wt.valid <= 1'b0;
            x = x + (m[1] ? (m[0] ? 64'h8 : 64'h4) : 64'h0);
            #1 check(dfva, x);
        end
        $display("test watchpoint done");
        u_core.access(1'b1, 8'h58, '1, a, rd);
        u_core.access(1'b0, 8'h58, '0, a, rd);
        check(rd, mmu_tlb_pkg::FPA_MASK);
        u_core.access(1'b0, 8'h59, '0, a, rd);
        check({a, rd}, 65'h0);
        x = 64'h0ab_cdef_1237;
        err(1'b0, 4'h0);
        u_core.access(1'b0, 8'h58, '0, a, rd);
        check(rd, mmu_tlb_pkg::FPA_MASK);
        for (int i = 0; i < 4; i++) begin
            x = x + 64'h10_0000;
            err(i[0], 4'(1 << i));
            u_core.access(1'b0, i[0] ? 8'h50 : 8'h58, '0, a, rd);
            check(rd, x & mmu_tlb_pkg::FPA_MASK);
        end
        $display("test fault registers done");
        wr(e1, 1'b0);
        lkup(e1.va, 1'b1);
        check(ppn, e1.ppn);
        dmap(mmu_tlb_pkg::DM_PAGE, mmu_tlb_pkg::CTX_SHARED);
        lkup(e1.va, 1'b1);
        dmap(mmu_tlb_pkg::DM_PAGE, mmu_tlb_pkg::CTX_PRIMARY);
        lkup(e1.va, 1'b0);
        wr(e1, 1'b0);
        @(posedge i_clock) cfg <= '{1'b0, 1'b1};
        wr(e1, 1'b0);
        wr(e1, 1'b1);
        lkup(e1.va, 1'b1);
        check(mhit, 1'b1);
        @(posedge i_clock) cfg <= '0;
        dmap(mmu_tlb_pkg::DM_ALL, mmu_tlb_pkg::CTX_PRIMARY);
        lkup(e1.va, 1'b0);
        f = e1;
        f.va = 48'h55_a000;
        f.psize = 2'h1;
        @(posedge i_clock);
        dv <= 1'b1;
        dset <= f.va[18:13];
        dent <= f;
        @(posedge i_clock);
        dv <= 1'b0;
        lkup(f.va, 1'b1);
        $display("test set-indexed done");
        f.lock = 1'b1;
        wr(f, 1'b0);
        wr(f, 1'b1);
        for (int i = 1; i < 17; i++) begin
            f.va = 48'h7000_0000 + 48'(i << 16);
            wr(f, i == 16);
        end
        lkup(48'h7003_0000, 1'b1);
        lkup(f.va, 1'b0);
        $display("test fully searched done");
        close_out();
    end
endmodule
bind mmu_tlb_replace_demap_fault_addr mmu_tlb_sva u_sva (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_watch(i_watch),
    .o_data_fault_virt_address(o_data_fault_virt_address),
    .i_reg(i_reg), .o_reg_ack(o_reg_ack), .o_reg_rdata(o_reg_rdata),
    .i_bypass_valid(i_bypass_valid), .i_bypass_asi(i_bypass_asi),
    .o_bypass_hit(o_bypass_hit), .o_bypass_attr(o_bypass_attr));
